// *** core/scg_params.svh ***
// Constants of the sleep-mode clock gating block: offsets, fields, resets.
// Assumes a 32-bit classic Wishbone slave port with byte addresses.
`ifndef SCG_PARAMS_SVH
`define SCG_PARAMS_SVH

`define SCG_ADR_W          12
`define SCG_NUM_UNITS      3
`define SCG_STAT_W         3

`define SCG_SLEEP_GATE_OFS 12'h110
`define SCG_STATUS_OFS     12'h200
`define SCG_MASK_OFS       12'h204

`define SCG_ADC_BIT        16
`define SCG_RATE_HI        9
`define SCG_RATE_LO        8
`define SCG_HIB_BIT        6
`define SCG_WDT_BIT        3

`define SCG_UNIT_ADC       0
`define SCG_UNIT_HIB       1
`define SCG_UNIT_WDT       2

`define SCG_GATE_RESET     1'h0
`define SCG_RATE_RESET     2'h0
`define SCG_STAT_RESET     3'h0
`define SCG_MASK_RESET     3'h0
`define SCG_WORD_ZERO      32'h0000_0000

`endif

// *** core/scg_pkg.sv ***
// Types shared by the sleep-mode clock gating block.
// Assumes scg_params.svh supplies the status and mask widths.
`include "scg_params.svh"
`default_nettype none

package scg_pkg;

    typedef enum logic [1:0] {
        SCG_PM_RUN,
        SCG_PM_SLEEP,
        SCG_PM_DEEP
    } scg_power_mode_t;

    typedef enum logic [1:0] {
        SCG_RATE_125K,
        SCG_RATE_250K,
        SCG_RATE_500K,
        SCG_RATE_1M
    } scg_rate_t;

    typedef struct packed {
        logic clk_en;
        logic fault;
    } scg_unit_state_t;

    typedef struct packed {
        logic                    adc_gate;
        logic [1:0]              rate;
        logic                    hib_gate;
        logic                    wdt_gate;
        logic [`SCG_STAT_W-1:0]  status;
        logic [`SCG_STAT_W-1:0]  mask;
        logic                    irq;
        logic                    ack;
        logic                    err;
        logic [31:0]             rdata;
    } scg_top_state_t;

endpackage

`default_nettype wire

// *** core/scg_top.sv ***
// Sleep-mode clock gating register with per-unit clock enables,
// access fault detection and a fault interrupt.
// Assumes a classic Wishbone master on the system clock, a decoder
// that pulses unit_access_i per peripheral access, and external
// clock gate cells driven by unit_clk_en_o.
//
// Overview of operation
// RULE1 - An enable bit at one lets its unit receive a clock and run.
// RULE2 - An enable bit at zero stops the unit's clock to save power.
// RULE3 - Any access to a unit whose clock is gated gives a bus fault.
// RULE4 - All gating bits reset to zero, units start unclocked.
// RULE5 - This register's gating applies only while the processor sleeps.
// RULE6 - Sleep gating is used only when automatic gating select is set.
// RULE7 - Bit 16 gates the converter clock during sleep, resets zero.
// RULE8 - Bits 9:8 pick converter rate: 3=1M, 2=500K, 1=250K, 0=125K.
// RULE9 - Software must not program a rate above the part's maximum.
// RULE10 - Bit 6 gates the low power unit clock during sleep, resets zero.
// RULE11 - Bit 3 gates the watchdog clock during sleep, resets zero.
// RULE12 - Software ignores reserved bits and writes them back unchanged.
// RULE13 - Reserved bits are read-only, read zero, ignore writes.
//
// Register access over Wishbone was decided locally.
`include "scg_params.svh"
`default_nettype none

module scg_top
    import scg_pkg::*;
#(
    parameter int NUM_UNITS = `SCG_NUM_UNITS
) (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,

    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [`SCG_ADR_W-1:0]   wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output var  logic [31:0]             wb_dat_o,
    output var  logic                    wb_ack_o,
    output var  logic                    wb_err_o,

    input  wire logic                    sleep_i,
    input  wire logic                    deep_sleep_i,
    input  wire logic                    auto_gating_select_i,
    input  wire logic [NUM_UNITS-1:0]    run_enable_i,
    input  wire logic [NUM_UNITS-1:0]    deep_enable_i,
    input  wire logic [NUM_UNITS-1:0]    unit_access_i,

    output var  logic [NUM_UNITS-1:0]    unit_clk_en_o,
    output var  logic [NUM_UNITS-1:0]    unit_fault_o,
    output var  logic [1:0]              converter_sample_rate_o,
    output var  logic                    irq_o
);

    scg_top_state_t          st;
    scg_top_state_t          next_st;

    logic [NUM_UNITS-1:0]    sleep_enable;
    logic [NUM_UNITS-1:0]    fault_pulse;
    logic [NUM_UNITS-1:0]    clk_en;

    logic                    req;
    logic                    hit_gate;
    logic                    hit_status;
    logic                    hit_mask;
    logic                    hit_any;
    logic [31:0]             wr_mask;
    logic [31:0]             gate_word;
    logic [31:0]             gate_new;
    logic [31:0]             rd_word;
    logic [`SCG_STAT_W-1:0]  mask_new;
    logic [`SCG_STAT_W-1:0]  stat_clear;

    // Byte lanes expanded to a bit mask for partial writes
    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        logic [31:0] m;
        m = `SCG_WORD_ZERO;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{sel[i]}};
        end
        return m;
    endfunction

    // Gating register image, reserved positions held at zero
    function automatic logic [31:0] pack_gate(input scg_top_state_t s);
        logic [31:0] w;
        w = `SCG_WORD_ZERO; // RULE13
        w[`SCG_ADC_BIT] = s.adc_gate;
        w[`SCG_RATE_HI:`SCG_RATE_LO] = s.rate;
        w[`SCG_HIB_BIT] = s.hib_gate;
        w[`SCG_WDT_BIT] = s.wdt_gate;
        return w;
    endfunction

    // Classic cycle: answer once per strobe, ack drops the cycle after
    assign req        = wb_cyc_i & wb_stb_i & ~st.ack & ~st.err;
    assign hit_gate   = (wb_adr_i[`SCG_ADR_W-1:2] == (`SCG_ADR_W-2)'(`SCG_SLEEP_GATE_OFS >> 2));
    assign hit_status = (wb_adr_i[`SCG_ADR_W-1:2] == (`SCG_ADR_W-2)'(`SCG_STATUS_OFS >> 2));
    assign hit_mask   = (wb_adr_i[`SCG_ADR_W-1:2] == (`SCG_ADR_W-2)'(`SCG_MASK_OFS >> 2));
    assign hit_any    = hit_gate | hit_status | hit_mask;
    assign wr_mask    = lane_mask(wb_sel_i);

    always_comb begin
        gate_word = pack_gate(st);
        // Only implemented bits take write data
        gate_new  = (gate_word & ~wr_mask) | (wb_dat_i & wr_mask); // RULE13
        mask_new  = (st.mask & ~wr_mask[`SCG_STAT_W-1:0])
                  | (wb_dat_i[`SCG_STAT_W-1:0] & wr_mask[`SCG_STAT_W-1:0]);
    end

    always_comb begin
        rd_word = `SCG_WORD_ZERO;
        if (hit_gate) begin
            rd_word = gate_word;
        end else if (hit_status) begin
            rd_word[`SCG_STAT_W-1:0] = st.status;
        end else if (hit_mask) begin
            rd_word[`SCG_STAT_W-1:0] = st.mask;
        end
    end

    // Sleep enables per unit, in unit index order
    always_comb begin
        sleep_enable = '0;
        sleep_enable[`SCG_UNIT_ADC] = st.adc_gate; // RULE7
        sleep_enable[`SCG_UNIT_HIB] = st.hib_gate; // RULE10
        sleep_enable[`SCG_UNIT_WDT] = st.wdt_gate; // RULE11
    end

    // Status read clears only bits already seen by this read
    always_comb begin
        stat_clear = '0;
        if (req && !wb_we_i && hit_status) begin
            stat_clear = st.status;
        end
    end

    always_comb begin
        next_st       = st;
        next_st.ack   = 1'b0;
        next_st.err   = 1'b0;
        next_st.rdata = `SCG_WORD_ZERO;

        if (req) begin
            if (!hit_any) begin
                next_st.err = 1'b1;
            end else begin
                next_st.ack = 1'b1;
                if (!wb_we_i) begin
                    next_st.rdata = rd_word;
                end
            end
        end

        if (req && wb_we_i && hit_gate) begin
            next_st.adc_gate = gate_new[`SCG_ADC_BIT]; // RULE7
            next_st.rate     = gate_new[`SCG_RATE_HI:`SCG_RATE_LO]; // RULE8
            next_st.hib_gate = gate_new[`SCG_HIB_BIT]; // RULE10
            next_st.wdt_gate = gate_new[`SCG_WDT_BIT]; // RULE11
        end

        if (req && wb_we_i && hit_mask) begin
            next_st.mask = mask_new;
        end

        // A new fault in the clearing cycle survives the clear
        next_st.status = (st.status & ~stat_clear) | fault_pulse;
        next_st.irq    = |(next_st.status & next_st.mask);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st.adc_gate <= `SCG_GATE_RESET; // RULE4
            st.rate     <= `SCG_RATE_RESET;
            st.hib_gate <= `SCG_GATE_RESET;
            st.wdt_gate <= `SCG_GATE_RESET;
            st.status   <= `SCG_STAT_RESET;
            st.mask     <= `SCG_MASK_RESET;
            st.irq      <= 1'b0;
            st.ack      <= 1'b0;
            st.err      <= 1'b0;
            st.rdata    <= `SCG_WORD_ZERO;
        end else begin
            st <= next_st;
        end
    end

    // One gate per unit; selection of the active enable set lives there
    for (genvar u = 0; u < NUM_UNITS; u++) begin : g_unit
        scg_unit_gate u_gate (
            .clk_i                (clk_i),
            .rst_i                (rst_i),
            .auto_gating_select_i (auto_gating_select_i),
            .sleep_i              (sleep_i),
            .deep_sleep_i         (deep_sleep_i),
            .run_enable_i         (run_enable_i[u]),
            .sleep_enable_i       (sleep_enable[u]),
            .deep_enable_i        (deep_enable_i[u]),
            .access_i             (unit_access_i[u]),
            .clk_en_o             (clk_en[u]),
            .fault_o              (fault_pulse[u])
        );
    end

    assign wb_dat_o                = st.rdata;
    assign wb_ack_o                = st.ack;
    assign wb_err_o                = st.err;
    assign unit_clk_en_o           = clk_en; // RULE1 RULE2
    assign unit_fault_o            = fault_pulse; // RULE3
    // Rate passes through unchecked; limiting it is software's job
    assign converter_sample_rate_o = st.rate; // RULE8
    assign irq_o                   = st.irq;

endmodule

`default_nettype wire

// *** core/scg_unit_gate.sv ***
// One unit's effective clock enable and its access fault detector.
// Assumes access_i is a one-cycle pulse from the system bus decoder.
`include "scg_params.svh"
`default_nettype none

module scg_unit_gate
    import scg_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic auto_gating_select_i,
    input  wire logic sleep_i,
    input  wire logic deep_sleep_i,
    input  wire logic run_enable_i,
    input  wire logic sleep_enable_i,
    input  wire logic deep_enable_i,
    input  wire logic access_i,
    output var  logic clk_en_o,
    output var  logic fault_o
);

    scg_unit_state_t st;
    scg_unit_state_t next_st;
    scg_power_mode_t mode;

    always_comb begin
        // Sleep registers only count with automatic gating on
        if (!auto_gating_select_i) begin // RULE6
            mode = SCG_PM_RUN;
        end else if (deep_sleep_i) begin
            mode = SCG_PM_DEEP;
        end else if (sleep_i) begin
            mode = SCG_PM_SLEEP;
        end else begin
            mode = SCG_PM_RUN;
        end
    end

    always_comb begin
        next_st = st;
        case (mode)
            SCG_PM_SLEEP: next_st.clk_en = sleep_enable_i; // RULE5
            SCG_PM_DEEP:  next_st.clk_en = deep_enable_i;
            SCG_PM_RUN:   next_st.clk_en = run_enable_i;
            default:      next_st.clk_en = run_enable_i;
        endcase
        // Fault judged on the enable the unit sees this cycle
        next_st.fault = access_i & ~st.clk_en; // RULE3
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st.clk_en <= `SCG_GATE_RESET; // RULE4
            st.fault  <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign clk_en_o = st.clk_en; // RULE1 RULE2
    assign fault_o  = st.fault;

endmodule

`default_nettype wire

// *** dv/scg_top_assertions.sv ***
// Port-level checker for the sleep clock gating block.
// Assumes one clock domain and a synchronous active-high reset.
`include "scg_params.svh"
`default_nettype none

module scg_top_assertions #(
    parameter int NUM_UNITS = `SCG_NUM_UNITS
) (
    input wire logic                 clk_i,
    input wire logic                 rst_i,
    input wire logic                 wb_cyc_i,
    input wire logic                 wb_stb_i,
    input wire logic                 wb_we_i,
    input wire logic [`SCG_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0]           wb_sel_i,
    input wire logic [31:0]          wb_dat_i,
    input wire logic [31:0]          wb_dat_o,
    input wire logic                 wb_ack_o,
    input wire logic                 wb_err_o,
    input wire logic                 sleep_i,
    input wire logic                 deep_sleep_i,
    input wire logic                 auto_gating_select_i,
    input wire logic [NUM_UNITS-1:0] run_enable_i,
    input wire logic [NUM_UNITS-1:0] deep_enable_i,
    input wire logic [NUM_UNITS-1:0] unit_access_i,
    input wire logic [NUM_UNITS-1:0] unit_clk_en_o,
    input wire logic [NUM_UNITS-1:0] unit_fault_o,
    input wire logic [1:0]           converter_sample_rate_o,
    input wire logic                 irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic [11:0] wadr;
    logic        gate;
    logic        mapped;
    assign wadr = {wb_adr_i[11:2], 2'b00};
    assign gate = wadr == `SCG_SLEEP_GATE_OFS;
    assign mapped = gate || wadr == `SCG_STATUS_OFS || wadr == `SCG_MASK_OFS;

    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    endsequence
    sequence s_sleep_idle;
        auto_gating_select_i && sleep_i && !deep_sleep_i && !(wb_cyc_i && wb_stb_i);
    endsequence

    property p_reset_zero;
        $fell(rst_i) |-> unit_clk_en_o == 0 && converter_sample_rate_o == 0 && !irq_o;
    endproperty
    property p_fault;
        1 |=> unit_fault_o == ($past(unit_access_i) & ~$past(unit_clk_en_o));
    endproperty
    property p_run;
        !auto_gating_select_i || !(sleep_i || deep_sleep_i)
            |=> unit_clk_en_o == $past(run_enable_i);
    endproperty
    property p_deep;
        auto_gating_select_i && deep_sleep_i |=> unit_clk_en_o == $past(deep_enable_i);
    endproperty
    property p_sleep_hold;
        s_sleep_idle ##1 s_sleep_idle |=> $stable(unit_clk_en_o);
    endproperty
    property p_sleep_gate;
        s_req ##0 (!wb_we_i && gate && auto_gating_select_i && sleep_i && !deep_sleep_i)
            |=> unit_clk_en_o == {wb_dat_o[`SCG_WDT_BIT], wb_dat_o[`SCG_HIB_BIT],
                                  wb_dat_o[`SCG_ADC_BIT]};
    endproperty
    property p_rate;
        s_req ##0 (wb_we_i && gate && wb_sel_i[1])
            |=> converter_sample_rate_o == $past(wb_dat_i[9:8]);
    endproperty
    property p_rsvd;
        s_req ##0 (!wb_we_i && gate) |=> wb_ack_o && (wb_dat_o & 32'hfffe_fcb7) == 0;
    endproperty
    property p_unmapped;
        s_req ##0 !mapped |=> wb_err_o && !wb_ack_o && wb_dat_o == 0;
    endproperty
    property p_ack_once;
        wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o;
    endproperty

    a_reset_zero: assert property (p_reset_zero) else $error("outputs not zero at reset");
    a_fault: assert property (p_fault) else $error("fault does not match gated access");
    a_run: assert property (p_run) else $error("run enables not applied");
    a_deep: assert property (p_deep) else $error("deep enables not applied");
    a_sleep_hold: assert property (p_sleep_hold) else $error("sleep enable moved");
    a_sleep_gate: assert property (p_sleep_gate) else $error("sleep gate bits not applied");
    a_rate: assert property (p_rate) else $error("sample rate not written");
    a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    a_ack_once: assert property (p_ack_once) else $error("answer longer than one cycle");
endmodule

bind scg_top scg_top_assertions #(.NUM_UNITS(NUM_UNITS)) scg_top_assertions_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .sleep_i(sleep_i),
    .deep_sleep_i(deep_sleep_i), .auto_gating_select_i(auto_gating_select_i),
    .run_enable_i(run_enable_i), .deep_enable_i(deep_enable_i),
    .unit_access_i(unit_access_i), .unit_clk_en_o(unit_clk_en_o),
    .unit_fault_o(unit_fault_o), .converter_sample_rate_o(converter_sample_rate_o),
    .irq_o(irq_o));

`default_nettype wire

// *** dv/scg_top_tb.sv ***
// Self-checking bench for the sleep clock gating block.
// Assumes each bus request is answered one cycle after it is taken.
`include "scg_params.svh"
`default_nettype none

module scg_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [31:0] wdat;
        logic [3:0]  sel;
        logic [31:0] exp;
    } scg_row_t;

    logic        clk_i = 1'b0, rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0, rd, wb_dat_o;
    logic        er, wb_ack_o, wb_err_o, irq_o;
    logic        sleep = 1'b0, deep = 1'b0, auto = 1'b0;
    logic [2:0]  run_en = 3'h0, deep_en = 3'h0, access = 3'h0;
    logic [2:0]  unit_clk_en_o, unit_fault_o;
    logic [1:0]  converter_sample_rate_o;
    int          n_fail = 0, tests_run = 0, cycles = 0;
    // Lane 2 and lane 0 writes prove byte enables keep other fields
    scg_row_t    rows [7] = '{'{32'hffff_ffff, 4'hf, 32'h0001_0348},
        '{32'h0, 4'hf, 32'h0}, '{32'h0000_0100, 4'hf, 32'h0000_0100},
        '{32'h0000_0200, 4'hf, 32'h0000_0200}, '{32'h0001_0000, 4'h4, 32'h0001_0200},
        '{32'h0000_0048, 4'h1, 32'h0001_0248}, '{32'hffff_ffff, 4'h0, 32'h0001_0248}};

    scg_top scg_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .sleep_i(sleep), .deep_sleep_i(deep),
        .auto_gating_select_i(auto), .run_enable_i(run_en), .deep_enable_i(deep_en),
        .unit_access_i(access), .unit_clk_en_o(unit_clk_en_o), .unit_fault_o(unit_fault_o),
        .converter_sample_rate_o(converter_sample_rate_o), .irq_o(irq_o));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    task automatic print_verdict();
        if (n_fail == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Generous ceiling; the whole sequence needs about 120 cycles
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_fail++;
            print_verdict();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic bus(input logic w, input logic [11:0] a, input logic [3:0] s,
                       input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        dat <= d;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
        rd = wb_dat_o;
        er = wb_err_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic mode(input logic a, input logic s, input logic d, input logic [2:0] exp);
        auto <= a;
        sleep <= s;
        deep <= d;
        repeat (3) @(posedge clk_i);
        chk("clk_en_mode", 32'(exp), 32'(unit_clk_en_o));
    endtask

    task automatic fault(input logic [2:0] acc, input logic [2:0] exp, input logic irq);
        access <= acc;
        @(posedge clk_i);
        access <= 3'h0;
        @(posedge clk_i);
        chk("fault", 32'(exp), 32'(unit_fault_o));
        @(posedge clk_i);
        // Status and interrupt follow the fault flag by one edge
        chk("irq", 32'(irq), 32'(irq_o));
        chk("fault_end", 32'h0, 32'(unit_fault_o));
    endtask

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        bus(1'b0, `SCG_SLEEP_GATE_OFS, 4'hf, 32'h0);
        chk("gate_reset", 32'h0, rd);
        auto <= 1'b1;
        sleep <= 1'b1;
        run_en <= 3'h7;
        deep_en <= 3'h7;
        foreach (rows[i]) begin
            // Rate codes stay within the documented table
            bus(1'b1, `SCG_SLEEP_GATE_OFS, rows[i].sel, rows[i].wdat);
            bus(1'b0, `SCG_SLEEP_GATE_OFS, 4'hf, 32'h0);
            chk("gate_read", rows[i].exp, rd);
            chk("rate", 32'(rows[i].exp[9:8]), 32'(converter_sample_rate_o));
            chk("clk_en_sleep", 32'({rows[i].exp[3], rows[i].exp[6], rows[i].exp[16]}),
                32'(unit_clk_en_o));
        end
        run_en <= 3'h2;
        deep_en <= 3'h4;
        mode(1'b0, 1'b1, 1'b0, 3'h2);
        mode(1'b1, 1'b0, 1'b0, 3'h2);
        mode(1'b1, 1'b1, 1'b1, 3'h4);
        mode(1'b1, 1'b1, 1'b0, 3'h7);
        // Read-modify-write keeps reserved bits as read, clears the watchdog gate
        bus(1'b0, `SCG_SLEEP_GATE_OFS, 4'hf, 32'h0);
        bus(1'b1, `SCG_SLEEP_GATE_OFS, 4'hf, rd & ~32'h0000_0008);
        bus(1'b0, `SCG_SLEEP_GATE_OFS, 4'hf, 32'h0);
        chk("gate_rmw", 32'h0001_0240, rd);
        mode(1'b1, 1'b1, 1'b0, 3'h3);
        run_en <= 3'h1;
        mode(1'b0, 1'b0, 1'b0, 3'h1);
        bus(1'b1, `SCG_MASK_OFS, 4'h1, 32'h2);
        fault(3'h7, 3'h6, 1'b1);
        bus(1'b0, `SCG_STATUS_OFS, 4'hf, 32'h0);
        chk("status", 32'h6, rd);
        chk("irq_clear", 32'h0, 32'(irq_o));
        fault(3'h4, 3'h4, 1'b0);
        bus(1'b0, `SCG_STATUS_OFS, 4'hf, 32'h0);
        chk("status_masked", 32'h4, rd);
        bus(1'b0, `SCG_STATUS_OFS, 4'hf, 32'h0);
        chk("status_empty", 32'h0, rd);
        bus(1'b0, 12'h300, 4'hf, 32'h0);
        chk("unmapped_err", 32'h1, 32'(er));
        chk("unmapped_dat", 32'h0, rd);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        bus(1'b0, `SCG_SLEEP_GATE_OFS, 4'hf, 32'h0);
        chk("gate_rereset", 32'h0, rd);
        print_verdict();
    end
endmodule

`default_nettype wire
